// ---- hw/tmc_map.svh ----
// register map, field positions and counts of the timer/counter
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMC_OFF_CNT_LO 12'h000
`define TMC_OFF_CNT_HI 12'h004
`define TMC_OFF_FLAG 12'h008
`define TMC_OFF_IEN 12'h00C
`define TMC_OFF_CTRL 12'h010

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define TMC_B_ON 0
`define TMC_B_CS 1
`define TMC_B_NSYNC 2
`define TMC_B_OSCEN 3
`define TMC_B_PS_LO 4
`define TMC_B_PS_HI 5
`define TMC_B_OVF 0
`define TMC_CTRL_RST 8'h00
`define TMC_CTRL_MASK 8'h3F
`define TMC_CNT_ZERO 16'h0000
`define TMC_CNT_WRAP 16'hFFFF

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define TMC_INSTR_DIV 4
`define TMC_PRE_W 3

`endif

// ---- hw/tmc_pkg.sv ----
// types shared by the timer/counter files
package tmc_pkg;

  // arming of the counter after enable
  typedef enum {
    TMC_OFF,
    TMC_WAIT_FALL,
    TMC_RUN
  } tmc_arm_t;

  typedef logic [1:0] tmc_ps_t;

endpackage

// ---- hw/tmc_prescale.sv ----
// prescaler in front of the 16-bit counter
`timescale 1ns/1ps
`include "tmc_map.svh"

module tmc_prescale (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire tmc_pkg::tmc_ps_t ratio_sel,
  // ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [`TMC_PRE_W-1:0] cnt_r;
  logic [`TMC_PRE_W-1:0] cnt_nxt;

  // ratio code to mask of low count bits: 1, 2, 4, 8
  function automatic logic [`TMC_PRE_W-1:0] ratio_mask(
    input tmc_pkg::tmc_ps_t sel);
    unique case (sel)
      2'h0: ratio_mask = 3'h0;
      2'h1: ratio_mask = 3'h1;
      2'h2: ratio_mask = 3'h3;
      2'h3: ratio_mask = 3'h7;
    endcase
  endfunction

  // output once every 2**sel input ticks
  assign tick_out = tick_in &&
    ((cnt_r & ratio_mask(ratio_sel)) == ratio_mask(ratio_sel));

  // count input ticks; a counter write restarts the ratio
  always_comb begin
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = '0;
    end else if (tick_in) begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> cnt_r == 3'h0)
    else $error("prescaler not cleared by counter write");

endmodule

// ---- hw/tmc_timer.sv ----
// 16-bit timer/counter with prescaler and APB registers
//
// Functional notes
// - counter runs 0000h up to FFFFh then wraps back to zero
// - every wrap sets overflow flag; interrupt only when enabled
// - control bit 1 picks instruction clock or external rising edges
// - instruction clock source counts once per cycle; sync bit ignored
// - count only while control bit 0 set; hold otherwise
// - oscillator enable picks crystal input pin, else clock pin
// - oscillator enable forces both oscillator pins to inputs
// - control bit 3 turns crystal inverter on or off
// - bit 2 clear syncs prescaler output; set counts unsynchronised
// - prescaler sits before the sync stage, fed by external or instruction clock
// - after enable in counter mode wait one falling edge first
// - synced counter mode in sleep holds count; prescaler keeps going
// - unsynced counter keeps counting in sleep; overflow wakes core when its interrupt is enabled
// - unsynced mode withdraws counter as capture/compare time base
// - byte reads always return a valid counter value
// - compare unit may clear the counter through an internal input
// - counter write wins over a simultaneous compare clear
// - any counter byte write clears the prescaler count
// - power-on reset clears control; counter bytes also reset to zero
`timescale 1ns/1ps
`include "tmc_map.svh"

module tmc_timer #(
  parameter int INSTR_DIV = `TMC_INSTR_DIV
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic sleep_mode,
  input wire logic ccp_clear,
  output logic [15:0] sixteen_bit_count,
  output logic time_base_ok,
  // oscillator pins, bit 1 crystal input, bit 0 clock pin
  input wire logic crystal_in_pin,
  input wire logic ext_clock_pin,
  input wire logic [1:0] port_c_out,
  input wire logic [1:0] port_c_direction,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic crystal_osc_enable,
  // events
  output logic overflow_flag,
  output logic overflow_irq,
  output logic wake_req
);

  localparam int DIV_W = $clog2(INSTR_DIV);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic flag_r;
  logic flag_nxt;
  logic ien_r;
  logic ien_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit;
  logic wr_lo;
  logic wr_hi;
  logic wr_cnt;

  // address match used by both the write decode and the error answer
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `TMC_OFF_CNT_LO) || (a == `TMC_OFF_CNT_HI) ||
      (a == `TMC_OFF_FLAG) || (a == `TMC_OFF_IEN) ||
      (a == `TMC_OFF_CTRL);
  endfunction

  assign setup = psel && !penable;
  assign hit = mapped(paddr);
  assign wr = psel && penable && pwrite && hit;
  assign wr_lo = wr && (paddr == `TMC_OFF_CNT_LO);
  assign wr_hi = wr && (paddr == `TMC_OFF_CNT_HI);
  assign wr_cnt = wr_lo || wr_hi;
  // zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic on_b;
  logic cs_b;
  logic nsync_b;
  logic osc_b;
  tmc_pkg::tmc_ps_t ps_b;

  assign on_b = ctrl_r[`TMC_B_ON];
  assign cs_b = ctrl_r[`TMC_B_CS];
  assign nsync_b = ctrl_r[`TMC_B_NSYNC] && cs_b;
  assign osc_b = ctrl_r[`TMC_B_OSCEN];
  assign ps_b = ctrl_r[`TMC_B_PS_HI:`TMC_B_PS_LO];

  // ----------------------------------------------------------------
  // pins and oscillator
  // ----------------------------------------------------------------
  // oscillator takes both pins as inputs, whatever direction says
  assign pin_oe = osc_b ? 2'h0 : ~port_c_direction;
  assign pin_out = port_c_out;
  assign crystal_osc_enable = osc_b;

  // two-flop synchroniser per pin, third flop for edges
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic ext_d_r;
  logic ext_lvl;
  logic ext_rise;
  logic ext_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      ext_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {crystal_in_pin, ext_clock_pin};
      pin_s2_r <= pin_s1_r;
      ext_d_r <= ext_lvl;
    end
  end

  // counter mode source pin follows the oscillator enable
  assign ext_lvl = osc_b ? pin_s2_r[1] : pin_s2_r[0];
  assign ext_rise = ext_lvl && !ext_d_r;
  assign ext_fall = !ext_lvl && ext_d_r;

  // ----------------------------------------------------------------
  // instruction cycle divider, stopped with the core in sleep
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic instr_tick;

  assign instr_tick = !sleep_mode &&
    (div_r == DIV_W'(INSTR_DIV - 1));

  always_comb begin
    div_nxt = div_r;
    if (!sleep_mode) begin
      div_nxt = instr_tick ? '0 : div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------------------------------
  // arming: counter mode needs a falling edge before counting
  // ----------------------------------------------------------------
  tmc_pkg::tmc_arm_t arm_r;
  tmc_pkg::tmc_arm_t arm_nxt;

  always_comb begin
    arm_nxt = arm_r;
    unique case (arm_r)
      tmc_pkg::TMC_OFF: begin
        if (on_b && cs_b) begin
          arm_nxt = tmc_pkg::TMC_WAIT_FALL;
        end
      end
      tmc_pkg::TMC_WAIT_FALL: begin
        if (!(on_b && cs_b)) begin
          arm_nxt = tmc_pkg::TMC_OFF;
        end else if (ext_fall) begin
          arm_nxt = tmc_pkg::TMC_RUN;
        end
      end
      tmc_pkg::TMC_RUN: begin
        if (!(on_b && cs_b)) begin
          arm_nxt = tmc_pkg::TMC_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= tmc_pkg::TMC_OFF;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and sync stage
  // ----------------------------------------------------------------
  logic pre_in;
  logic pre_out;
  logic sync_r;
  logic inc;

  // prescaler sees raw edges, ahead of any sync or sleep gating
  assign pre_in = cs_b ? (ext_rise && arm_r == tmc_pkg::TMC_RUN) :
    (on_b && instr_tick);

  tmc_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wr_cnt),
    .ratio_sel(ps_b),
    .tick_in(pre_in),
    .tick_out(pre_out)
  );

  // synced path costs one cycle and dies in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 1'b0;
    end else begin
      sync_r <= pre_out && !sleep_mode;
    end
  end

  // unsynced path counts straight from the prescaler, even in sleep
  assign inc = on_b && (!cs_b ? pre_out :
    (nsync_b ? pre_out : sync_r));

  // ----------------------------------------------------------------
  // counter, flag and registers
  // ----------------------------------------------------------------
  logic wrap;
  logic ccp_ok;

  assign wrap = inc && (cnt_r == `TMC_CNT_WRAP);
  // the clear is unreliable unsynchronised, so it is ignored there
  assign ccp_ok = ccp_clear && !nsync_b;

  always_comb begin
    cnt_nxt = cnt_r;
    ctrl_nxt = ctrl_r;
    ien_nxt = ien_r;
    flag_nxt = flag_r;
    if (wr_lo) begin
      cnt_nxt = {cnt_r[15:8], pwdata[7:0]};
    end else if (wr_hi) begin
      cnt_nxt = {pwdata[7:0], cnt_r[7:0]};
    end else if (ccp_ok) begin
      cnt_nxt = `TMC_CNT_ZERO;
    end else if (inc) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (wr && paddr == `TMC_OFF_CTRL) begin
      ctrl_nxt = pwdata[7:0] & `TMC_CTRL_MASK;
    end
    if (wr && paddr == `TMC_OFF_IEN) begin
      ien_nxt = pwdata[`TMC_B_OVF];
    end
    if (wr && paddr == `TMC_OFF_FLAG) begin
      flag_nxt = pwdata[`TMC_B_OVF];
    end
    // a wrap in the clearing cycle still leaves the flag set
    if (wrap) begin
      flag_nxt = 1'b1;
    end
  end

  // power-on reset only: control to 00h; count starts at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TMC_CTRL_RST;
      cnt_r <= `TMC_CNT_ZERO;
      flag_r <= 1'b0;
      ien_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
      ien_r <= ien_nxt;
    end
  end

  // read data captured in setup; single clock so always coherent
  always_comb begin
    rdata_nxt = rdata_r;
    if (setup) begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `TMC_OFF_CNT_LO: rdata_nxt[7:0] = cnt_r[7:0];
        `TMC_OFF_CNT_HI: rdata_nxt[7:0] = cnt_r[15:8];
        `TMC_OFF_FLAG: rdata_nxt[0] = flag_r;
        `TMC_OFF_IEN: rdata_nxt[0] = ien_r;
        `TMC_OFF_CTRL: rdata_nxt[7:0] = ctrl_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = rdata_r;
  assign sixteen_bit_count = cnt_r;
  assign time_base_ok = !nsync_b;
  assign overflow_flag = flag_r;
  assign overflow_irq = flag_r && ien_r;
  assign wake_req = overflow_irq && sleep_mode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tick;
    instr_tick;
  endsequence

  sequence s_awake;
    !sleep_mode [*4];
  endsequence

  // sleep freezes the divider, so only awake stretches are measured
  a_instr_period: assert property (
    s_tick ##1 s_awake |-> instr_tick && !$past(instr_tick, 1) &&
      !$past(instr_tick, 2) && !$past(instr_tick, 3))
    else $error("instruction tick spacing wrong");

  a_wrap_sets_flag: assert property (
    wrap && !wr_cnt && !ccp_ok |=> flag_r && cnt_r == 16'h0000)
    else $error("wrap did not set flag and zero count");

  a_irq_gated: assert property (
    wrap |=> overflow_irq == ien_r)
    else $error("irq not following enable after wrap");

  a_hold_off: assert property (
    !on_b && !wr_cnt && !ccp_ok |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_write_wins: assert property (
    wr_lo && ccp_clear |=> cnt_r[7:0] == $past(pwdata[7:0]))
    else $error("compare clear beat counter write");

  a_wait_fall: assert property (
    arm_r == tmc_pkg::TMC_WAIT_FALL && !wr_cnt && !ccp_ok
      |=> $stable(cnt_r))
    else $error("counted before falling edge");

  a_sleep_sync: assert property (
    sleep_mode && cs_b && !nsync_b && $past(sleep_mode) && !wr_cnt
      && !ccp_ok |=> $stable(cnt_r))
    else $error("synced counter moved in sleep");

  a_pins_input: assert property (
    osc_b |-> pin_oe == 2'h0)
    else $error("oscillator pin driven");

  a_osc_follow: assert property (
    wr && paddr == `TMC_OFF_CTRL |=> crystal_osc_enable ==
      $past(pwdata[`TMC_B_OSCEN]))
    else $error("inverter enable not following control");

  a_no_timebase: assert property (
    cs_b && ctrl_r[`TMC_B_NSYNC] |-> !time_base_ok)
    else $error("time base offered unsynchronised");

endmodule

// ---- verification/tmc_ext_src.sv ----
// external clock source model for the timer's counter pins
`timescale 1ns/1ps

module tmc_ext_src (
  // clock
  input wire logic pclk,
  // control from the bench
  input wire logic run,
  input wire logic use_osc,
  input wire logic [3:0] half,
  // pins
  output logic crystal_in_pin,
  output logic ext_clock_pin
);
  logic level;
  logic [3:0] cnt;

  // ------------------------------------------------------------
  // square wave
  // ------------------------------------------------------------
  initial begin
    level = 1'b0;
    cnt = 4'h0;
  end

  // sleep is not seen here: the source keeps running
  always @(posedge pclk) begin
    if (!run) begin
      level <= 1'b0; // stands still low between bursts
      cnt <= 4'h0;
    end else if (cnt == half - 4'h1) begin
      level <= ~level;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // only the selected pin moves, so a wrong pick counts nothing
  assign crystal_in_pin = use_osc & level;
  assign ext_clock_pin = ~use_osc & level;
endmodule

// ---- verification/tmc_timer_tb.sv ----
// self-checking testbench of the timer/counter
`timescale 1ns/1ps
`include "tmc_map.svh"

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tmc_timer_tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} tmc_row_t;
  typedef struct {logic [7:0] c; logic slp; logic counts;} tmc_case_t;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic sleep_mode, ccp_clear, time_base_ok, crystal_osc_enable;
  logic [15:0] sixteen_bit_count, exp, c;
  logic crystal_in_pin, ext_clock_pin, run, use_osc, prev, p, fell, err;
  logic [1:0] port_c_out, port_c_direction, pin_out, pin_oe;
  logic overflow_flag, overflow_irq, wake_req;
  logic [3:0] half;
  int num_errors = 0;
  int comparisons = 0;
  int n;

  tmc_row_t regs[6] = '{
    '{`TMC_OFF_CNT_LO, 32'hA5, 32'hA5},
    '{`TMC_OFF_CNT_HI, 32'h5A, 32'h5A},
    '{`TMC_OFF_IEN, 32'hFF, 32'h01},
    '{`TMC_OFF_FLAG, 32'hFF, 32'h01},
    '{`TMC_OFF_CTRL, 32'hFE, 32'h3E},
    '{`TMC_OFF_CTRL, 32'h00, 32'h00}};
  // synced, crystal pin, unsynced in sleep, synced in sleep
  tmc_case_t cases[4] = '{'{8'h03, 1'b0, 1'b1}, '{8'h0B, 1'b0, 1'b1},
    '{8'h07, 1'b1, 1'b1}, '{8'h03, 1'b1, 1'b0}};

  tmc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .ccp_clear(ccp_clear),
    .sixteen_bit_count(sixteen_bit_count), .time_base_ok(time_base_ok),
    .crystal_in_pin(crystal_in_pin), .ext_clock_pin(ext_clock_pin),
    .port_c_out(port_c_out), .port_c_direction(port_c_direction),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .crystal_osc_enable(crystal_osc_enable),
    .overflow_flag(overflow_flag), .overflow_irq(overflow_irq),
    .wake_req(wake_req));

  tmc_ext_src src_u (.pclk(pclk), .run(run), .use_osc(use_osc),
    .half(half), .crystal_in_pin(crystal_in_pin),
    .ext_clock_pin(ext_clock_pin));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task timed_out;
    num_errors++;
    $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
    wrap_up();
  endtask

  task done(input string name);
    $display("test %s finished", name);
  endtask

  task tick;
    @(posedge pclk);
    #1;
  endtask

  // one apb transfer; clr raises the compare clear on the access edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
      input logic clr, output logic [31:0] rd, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    ccp_clear <= clr;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ccp_clear <= 1'b0;
    // callers look only after this edge's register updates settle
    #1;
    if (k >= 50) timed_out();
  endtask

  task wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic e;
    apb(a, 1'b1, wd, 1'b0, x, e);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] x);
    logic e;
    apb(a, 1'b0, 32'h0, 1'b0, x, e);
  endtask

  // stop, load the count, then start with the given control
  task setup(input logic [7:0] ctl, input logic [15:0] v);
    wr(`TMC_OFF_CTRL, 32'h0);
    wr(`TMC_OFF_CNT_LO, {24'h0, v[7:0]});
    wr(`TMC_OFF_CNT_HI, {24'h0, v[15:8]});
    wr(`TMC_OFF_CTRL, {24'h0, ctl});
  endtask

  task wait_change(output int m);
    logic [15:0] s;
    s = sixteen_bit_count;
    m = 0;
    do begin
      tick();
      m++;
    end while (sixteen_bit_count === s && m < 300);
    if (m >= 300) timed_out();
  endtask

  // high, low, high again; a carry in between forces a fresh low byte
  task read16(output logic [15:0] v);
    logic [31:0] h1, l, h2;
    rd(`TMC_OFF_CNT_HI, h1);
    rd(`TMC_OFF_CNT_LO, l);
    rd(`TMC_OFF_CNT_HI, h2);
    if (h2 !== h1) rd(`TMC_OFF_CNT_LO, l);
    v = {h2[7:0], l[7:0]};
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_mode, ccp_clear, run, use_osc} = '0;
    port_c_out = 2'b10;
    port_c_direction = 2'b01;
    half = 4'h3; // pulses stay at least two cycles wide
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMC_OFF_CTRL, d);
    `CHK(d, 32'h0)
    `CHK(time_base_ok, 1'b1)
    `CHK(pin_oe, 2'b10)
    `CHK(pin_out, 2'b10)
    done("reset");
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rd(regs[i].a, d);
      `CHK(d, regs[i].e)
    end
    apb(12'h020, 1'b0, 32'h0, 1'b0, d, err);
    `CHK(err, 1'b1)
    `CHK(d, 32'h0)
    done("registers");
    // each ratio measured as cycles between two increments
    for (int ps = 0; ps < 4; ps++) begin
      setup({2'b00, 2'(ps), 4'h5}, 16'h0000);
      wait_change(n);
      wait_change(n);
      `CHK(n, 4 << ps)
    end
    done("prescale");
    wr(`TMC_OFF_IEN, 32'h1);
    wr(`TMC_OFF_FLAG, 32'h0);
    setup(8'h01, 16'hFFFF);
    wait_change(n);
    `CHK(sixteen_bit_count, 16'h0000)
    `CHK(overflow_flag, 1'b1)
    `CHK(overflow_irq, 1'b1)
    @(posedge pclk) sleep_mode <= 1'b1;
    tick();
    `CHK(wake_req, 1'b1)
    @(posedge pclk) sleep_mode <= 1'b0;
    wr(`TMC_OFF_IEN, 32'h0);
    `CHK(overflow_irq, 1'b0)
    wr(`TMC_OFF_CTRL, 32'h0);
    c = sixteen_bit_count;
    repeat (20) tick();
    `CHK(sixteen_bit_count, c)
    wr(`TMC_OFF_FLAG, 32'h0);
    `CHK(overflow_flag, 1'b0)
    done("overflow");
    // running count read across the low byte carry
    setup(8'h01, 16'h00FE);
    read16(c);
    `CHK(c >= 16'h00FE && c <= 16'h0104, 1'b1)
    wr(`TMC_OFF_CTRL, 32'h0);
    done("byte pair read");
    // pin starts low: its first rise comes before any fall
    foreach (cases[i]) begin
      @(posedge pclk);
      sleep_mode <= cases[i].slp;
      use_osc <= cases[i].c[3];
      setup(cases[i].c, 16'h0000);
      `CHK(crystal_osc_enable, cases[i].c[3])
      `CHK(pin_oe, cases[i].c[3] ? 2'b00 : 2'b10)
      `CHK(time_base_ok, ~cases[i].c[2])
      // crystal start-up allowance before its edges are relied on
      if (cases[i].c[3]) repeat (4) tick();
      {exp, fell, prev} = '0;
      @(posedge pclk) run <= 1'b1;
      repeat (60) begin
        tick();
        p = crystal_in_pin | ext_clock_pin;
        if (prev && !p) fell = 1'b1;
        if (!prev && p && fell) exp = exp + 16'h1;
        prev = p;
      end
      @(posedge pclk) run <= 1'b0;
      repeat (8) tick();
      `CHK(sixteen_bit_count, cases[i].counts ? exp : 16'h0)
    end
    @(posedge pclk) sleep_mode <= 1'b0;
    done("counter");
    // unsynchronised counter mode refuses the compare clear
    setup(8'h06, 16'h1234);
    @(posedge pclk) ccp_clear <= 1'b1;
    @(posedge pclk) ccp_clear <= 1'b0;
    tick();
    `CHK(sixteen_bit_count, 16'h1234)
    setup(8'h00, 16'h1234);
    @(posedge pclk) ccp_clear <= 1'b1;
    @(posedge pclk) ccp_clear <= 1'b0;
    tick();
    `CHK(sixteen_bit_count, 16'h0000)
    apb(`TMC_OFF_CNT_LO, 1'b1, 32'hC3, 1'b1, d, err);
    tick();
    `CHK(sixteen_bit_count[7:0], 8'hC3)
    done("compare clear");
    wr(`TMC_OFF_CTRL, 32'h31);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMC_OFF_CTRL, d);
    `CHK(d, 32'h0)
    done("second reset");
    wrap_up();
  end
endmodule
